// ### secp_pkg.sv
package secp_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned GAP_US = 1000;
  localparam int unsigned GAP_CYCLES = (CLK_HZ / 1000000) * GAP_US;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] NL_CODE = 8'h0a;
  localparam int unsigned CMD_DEPTH = 256;
  localparam int unsigned RSP_DEPTH = 256;
  localparam logic [1:0] LINK_PARALLEL = 2'h0;
  localparam logic [1:0] LINK_SERIAL = 2'h1;
  localparam logic [1:0] LINK_BIAS = 2'h2;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } secp_byte_t;
endpackage

// ### secp_top.sv
`timescale 1ns/1ps
module secp_top
  import secp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // mode settings
  input wire logic [1:0] remote_link_select,
  input wire logic talk_only,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // command to executer
  output secp_pkg::secp_byte_t cmd_out,
  output logic cmd_busy,
  input wire logic cmd_done,
  // response text from executer
  input wire secp_pkg::secp_byte_t rsp_in,
  // measurement results in talk only
  input wire secp_pkg::secp_byte_t meas_in,
  // link select state
  output logic serial_mode,
  output logic bias_source_control_mode,
  output logic parallel_mode
);
  import secp_pkg::*;

  ////////////////////////////////////////////////////////////////
  // mode decode
  function automatic logic [2:0] link_onehot(input logic [1:0] sel);
    link_onehot = 3'h0;
    unique case (sel)
      LINK_SERIAL: link_onehot = 3'h1;
      LINK_BIAS: link_onehot = 3'h2;
      default: link_onehot = 3'h4;
    endcase
  endfunction

  logic [2:0] next_modes;
  logic port_on;
  always_comb begin
    next_modes = link_onehot(remote_link_select);
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_mode <= 1'b0;
      bias_source_control_mode <= 1'b0;
      parallel_mode <= 1'b1;
    end else begin
      serial_mode <= next_modes[0];
      bias_source_control_mode <= next_modes[1];
      parallel_mode <= next_modes[2];
    end
  end
  assign port_on = serial_mode & ~talk_only;

  ////////////////////////////////////////////////////////////////
  // rx sync, three stages
  logic [2:0] rx_sync;
  logic rx_line;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync <= 3'h7;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rxd};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_line <= rx_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // receiver
  typedef enum logic [1:0] {SECP_RX_IDLE, SECP_RX_START, SECP_RX_DATA, SECP_RX_STOP} secp_rx_t;
  secp_rx_t rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic rx_got, next_rx_got;
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_got = 1'b0;
    unique case (rx_st)
      SECP_RX_IDLE: begin
        if (!rx_line) begin
          next_rx_st = SECP_RX_START;
          next_rx_cnt = 16'(HALF_CYCLES);
        end
      end
      SECP_RX_START: begin
        if (rx_cnt == 16'h0) begin
          next_rx_st = rx_line ? SECP_RX_IDLE : SECP_RX_DATA;
          next_rx_cnt = 16'(BIT_CYCLES - 1);
          next_rx_bit = 3'h0;
        end else begin
          next_rx_cnt = rx_cnt - 16'h1;
        end
      end
      SECP_RX_DATA: begin
        if (rx_cnt == 16'h0) begin
          next_rx_sh = {rx_line, rx_sh[7:1]};
          next_rx_cnt = 16'(BIT_CYCLES - 1);
          next_rx_bit = rx_bit + 3'h1;
          if (rx_bit == 3'(DATA_BITS - 1)) begin
            next_rx_st = SECP_RX_STOP;
          end
        end else begin
          next_rx_cnt = rx_cnt - 16'h1;
        end
      end
      SECP_RX_STOP: begin
        if (rx_cnt == 16'h0) begin
          next_rx_st = SECP_RX_IDLE;
          next_rx_got = rx_line;
        end else begin
          next_rx_cnt = rx_cnt - 16'h1;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st <= SECP_RX_IDLE;
      rx_cnt <= 16'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h0;
      rx_got <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_got <= next_rx_got;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command buffer and execution gate
  logic [7:0] cmd_mem [CMD_DEPTH];
  logic [7:0] cwr, next_cwr, crd, next_crd;
  logic accept, next_busy, echo_req, next_echo_req;
  logic [7:0] echo_byte, next_echo_byte;
  secp_byte_t next_cmd_out;
  logic echo_take;
  assign accept = rx_got & port_on & ~cmd_busy;
  always_comb begin
    next_cwr = cwr;
    next_crd = crd;
    next_busy = cmd_busy;
    next_cmd_out = '0;
    next_echo_req = echo_req & ~echo_take;
    next_echo_byte = echo_byte;
    if (accept) begin
      next_cwr = cwr + 8'h1;
      next_echo_req = 1'b1;
      next_echo_byte = rx_sh;
      if (rx_sh == NL_CODE) begin
        next_busy = 1'b1;
      end
    end
    if (cmd_busy && crd != cwr) begin
      next_crd = crd + 8'h1;
      next_cmd_out.valid = 1'b1;
      next_cmd_out.data = cmd_mem[crd];
      next_cmd_out.last = (cmd_mem[crd] == NL_CODE);
    end
    if (cmd_busy && crd == cwr && cmd_done) begin
      next_busy = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (accept) begin
      cmd_mem[cwr] <= rx_sh;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cwr <= 8'h0;
      crd <= 8'h0;
      cmd_busy <= 1'b0;
      cmd_out <= '0;
      echo_req <= 1'b0;
      echo_byte <= 8'h0;
    end else begin
      cwr <= next_cwr;
      crd <= next_crd;
      cmd_busy <= next_busy;
      cmd_out <= next_cmd_out;
      echo_req <= next_echo_req;
      echo_byte <= next_echo_byte;
    end
  end

  ////////////////////////////////////////////////////////////////
  // response buffer, query text or talk only results
  logic [7:0] rsp_mem [RSP_DEPTH];
  logic [7:0] rwr, next_rwr, rrd, next_rrd;
  logic rsp_push, rsp_take;
  logic [7:0] rsp_byte;
  assign rsp_push = talk_only ? meas_in.valid : (rsp_in.valid & port_on);
  assign rsp_byte = talk_only ? meas_in.data : rsp_in.data;
  always_comb begin
    next_rwr = rwr + 8'(rsp_push);
    next_rrd = rrd + 8'(rsp_take);
  end
  always_ff @(posedge core_clk) begin
    if (rsp_push) begin
      rsp_mem[rwr] <= rsp_byte;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rwr <= 8'h0;
      rrd <= 8'h0;
    end else begin
      rwr <= next_rwr;
      rrd <= next_rrd;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmitter
  typedef enum logic [1:0] {SECP_TX_IDLE, SECP_TX_SEND, SECP_TX_GAP} secp_tx_t;
  secp_tx_t tx_st, next_tx_st;
  logic [17:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic [9:0] tx_sh, next_tx_sh;
  logic tx_is_rsp, next_tx_is_rsp, next_txd;
  always_comb begin
    next_tx_st = tx_st;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_tx_is_rsp = tx_is_rsp;
    echo_take = 1'b0;
    rsp_take = 1'b0;
    next_txd = 1'b1;
    unique case (tx_st)
      SECP_TX_IDLE: begin
        if (echo_req) begin
          echo_take = 1'b1;
          next_tx_sh = {1'b1, echo_byte, 1'b0};
          next_tx_is_rsp = 1'b0;
          next_tx_st = SECP_TX_SEND;
        end else if (rrd != rwr) begin
          rsp_take = 1'b1;
          next_tx_sh = {1'b1, rsp_mem[rrd], 1'b0};
          next_tx_is_rsp = 1'b1;
          next_tx_st = SECP_TX_SEND;
        end
        next_tx_cnt = 18'(BIT_CYCLES - 1);
        next_tx_bit = 4'h0;
      end
      SECP_TX_SEND: begin
        next_txd = tx_sh[0];
        if (tx_cnt == 18'h0) begin
          next_tx_sh = {1'b1, tx_sh[9:1]};
          next_tx_cnt = 18'(BIT_CYCLES - 1);
          next_tx_bit = tx_bit + 4'h1;
          if (tx_bit == 4'h9) begin
            next_txd = 1'b1;
            next_tx_st = SECP_TX_IDLE;
          end
        end else begin
          next_tx_cnt = tx_cnt - 18'h1;
        end
      end
      SECP_TX_GAP: begin
        if (tx_cnt == 18'h0) begin
          next_tx_st = SECP_TX_IDLE;
        end else begin
          next_tx_cnt = tx_cnt - 18'h1;
        end
      end
      default: begin
        next_tx_st = SECP_TX_IDLE;
      end
    endcase
  end
  // gap after a response terminator
  logic [7:0] tx_char, next_tx_char;
  always_comb begin
    next_tx_char = tx_char;
    if (tx_st == SECP_TX_IDLE && next_tx_st == SECP_TX_SEND) begin
      next_tx_char = next_tx_sh[8:1];
    end
  end
  secp_tx_t tx_st_fix;
  logic [17:0] tx_cnt_fix;
  always_comb begin
    tx_st_fix = next_tx_st;
    tx_cnt_fix = next_tx_cnt;
    if (tx_st == SECP_TX_SEND && tx_cnt == 18'h0 && tx_bit == 4'h9 && tx_is_rsp && tx_char == NL_CODE) begin
      tx_st_fix = SECP_TX_GAP;
      tx_cnt_fix = 18'(GAP_CYCLES - 1);
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st <= SECP_TX_IDLE;
      tx_cnt <= 18'h0;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3ff;
      tx_is_rsp <= 1'b0;
      tx_char <= 8'h0;
      txd <= 1'b1;
    end else begin
      tx_st <= tx_st_fix;
      tx_cnt <= tx_cnt_fix;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      tx_is_rsp <= next_tx_is_rsp;
      tx_char <= next_tx_char;
      txd <= next_txd;
    end
  end
endmodule

// ### secp_assertions.sv
`timescale 1ns/1ps
module secp_assertions
  import secp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // mode settings
  input wire logic [1:0] remote_link_select,
  input wire logic talk_only,
  // serial pins
  input wire logic rxd,
  input wire logic txd,
  // command side
  input wire secp_pkg::secp_byte_t cmd_out,
  input wire logic cmd_busy,
  input wire logic cmd_done,
  // response side
  input wire secp_pkg::secp_byte_t rsp_in,
  input wire secp_pkg::secp_byte_t meas_in,
  // link state
  input wire logic serial_mode,
  input wire logic bias_source_control_mode,
  input wire logic parallel_mode
);
  import secp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // low run length on txd
  logic [31:0] low_run;
  logic [31:0] next_low_run;
  always_comb next_low_run = txd ? 32'h0 : low_run + 32'h1;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) low_run <= 32'h0;
    else low_run <= next_low_run;
  end
  ////////////////////////////////////////
  sequence s_first_byte;
    ##[1:3] cmd_out.valid;
  endsequence
  property p_onehot; $onehot({serial_mode, bias_source_control_mode, parallel_mode}); endproperty
  property p_dec_serial; remote_link_select == LINK_SERIAL |=> serial_mode; endproperty
  property p_dec_bias; remote_link_select == LINK_BIAS |=> bias_source_control_mode; endproperty
  property p_last_nl; cmd_out.valid && cmd_out.last |-> cmd_out.data == NL_CODE; endproperty
  property p_valid_busy; cmd_out.valid |-> cmd_busy; endproperty
  property p_drain; $rose(cmd_busy) |-> s_first_byte; endproperty
  property p_busy_mode; $rose(cmd_busy) |-> serial_mode && !talk_only; endproperty
  property p_bit_len; $rose(txd) |-> (low_run % BIT_CYCLES) == 0; endproperty
  a_onehot:
    assert property (p_onehot) else $error("link modes not one-hot");
  a_dec_serial:
    assert property (p_dec_serial) else $error("serial mode not decoded");
  a_dec_bias:
    assert property (p_dec_bias) else $error("bias mode not decoded");
  a_last_nl:
    assert property (p_last_nl) else $error("last byte is not new line");
  a_valid_busy:
    assert property (p_valid_busy) else $error("command byte outside busy");
  a_drain:
    assert property (p_drain) else $error("command bytes late");
  a_busy_mode:
    assert property (p_busy_mode) else $error("command taken in wrong mode");
  a_bit_len:
    assert property (p_bit_len) else $error("txd low time not whole bits");
endmodule

// ### secp_host.sv
`timescale 1ns/1ps
module secp_host
  import secp_pkg::*;
(
  // serial pins
  output logic rxd,
  input wire logic txd
);
  import secp_pkg::*;
  localparam int BIT_NS = BIT_CYCLES * 5;
  initial rxd = 1'b1;
  // low start, lsb first, high stop
  task automatic send(input logic [7:0] c);
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd = c[i];
      #(BIT_NS);
    end
    rxd = 1'b1;
    #(BIT_NS / 2);
  endtask
  // polls txd for a start bit, bounded wait of 16 bit times
  task automatic recv(output logic [7:0] c, output logic ok, output time t);
    int n;
    ok = 1'b0;
    c = 8'h00;
    t = 0;
    for (n = 0; n < 16 * BIT_CYCLES && txd !== 1'b0; n++) #5;
    if (txd === 1'b0) begin
      t = $time;
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        c[i] = txd;
      end
      #(BIT_NS);
      ok = (txd === 1'b1);
    end
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import secp_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] remote_link_select = 2'h0;
  logic talk_only = 1'b0;
  logic cmd_done = 1'b0;
  secp_byte_t rsp_in = '0;
  secp_byte_t meas_in = '0;
  secp_byte_t cmd_out;
  logic rxd, txd, cmd_busy, serial_mode, bias_source_control_mode, parallel_mode;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] exp_q[$];
  logic [7:0] rs[4];
  logic [7:0] b, c1, c2;
  logic ok;
  time t0, t1;
  always #2.5 core_clk = ~core_clk;
  secp_top DUT (.core_clk(core_clk), .arst_n(arst_n), .remote_link_select(remote_link_select),
    .talk_only(talk_only), .rxd(rxd), .txd(txd), .cmd_out(cmd_out), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .rsp_in(rsp_in), .meas_in(meas_in), .serial_mode(serial_mode),
    .bias_source_control_mode(bias_source_control_mode), .parallel_mode(parallel_mode));
  secp_host host (.rxd(rxd), .txd(txd));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one character, then await its echo
  task automatic echo(input logic [7:0] c, input logic exp_ok);
    host.send(c);
    host.recv(b, ok, t0);
    chk(ok, exp_ok, "echo presence");
    if (exp_ok) chk(b, c, "echo value");
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  // command bytes against model queue
  always @(negedge core_clk) begin
    if (arst_n && cmd_out.valid === 1'b1) begin
      chk({cmd_out.last, cmd_out.data}, {exp_q[0] == NL_CODE, exp_q[0]}, "command byte");
      void'(exp_q.pop_front());
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hea8ca993));
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      tick();
      remote_link_select = k[1:0];
      repeat (2) tick();
      chk({parallel_mode, serial_mode, bias_source_control_mode}, k == 1 ? 3'b010 : k == 2 ? 3'b001 : 3'b100,
        "mode decode");
    end
    c1 = 8'h41 + 8'($urandom % 26);
    c2 = 8'h41 + 8'($urandom % 26);
    echo(c1, 1'b0);
    remote_link_select = LINK_SERIAL;
    talk_only = 1'b1;
    echo(c1, 1'b0);
    talk_only = 1'b0;
    exp_q.push_back(c1);
    echo(c1, 1'b1);
    exp_q.push_back(NL_CODE);
    echo(NL_CODE, 1'b1);
    chk(cmd_busy, 1'b1, "busy after new line");
    echo(c2, 1'b0);
    rs = '{c2, NL_CODE, c1, NL_CODE};
    foreach (rs[i]) begin
      tick();
      rsp_in = '{1'b1, rs[i], rs[i] == NL_CODE};
    end
    tick();
    rsp_in = '0;
    for (int i = 0; i < 4; i++) begin
      host.recv(b, ok, t0);
      chk({ok, b}, {1'b1, rs[i]}, "response byte");
      if (i == 2) chk((t0 - t1) / 5 - 10 * BIT_CYCLES - GAP_CYCLES <= BIT_CYCLES, 1'b1, "gap");
      t1 = t0;
    end
    tick();
    cmd_done = 1'b1;
    tick();
    cmd_done = 1'b0;
    for (int n = 0; n < 100 && cmd_busy !== 1'b0; n++) tick();
    chk(cmd_busy, 1'b0, "busy ends");
    echo(c2, 1'b1);
    chk(exp_q.size(), 0, "command bytes left");
    talk_only = 1'b1;
    tick();
    meas_in = '{1'b1, c2, 1'b0};
    tick();
    meas_in = '0;
    host.recv(b, ok, t0);
    chk({ok, b}, {1'b1, c2}, "talk only result");
    wrap_up();
  end
endmodule
bind secp_top secp_assertions u_chk (.core_clk(core_clk), .arst_n(arst_n), .remote_link_select(remote_link_select),
  .talk_only(talk_only), .rxd(rxd), .txd(txd), .cmd_out(cmd_out), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
  .rsp_in(rsp_in), .meas_in(meas_in), .serial_mode(serial_mode),
  .bias_source_control_mode(bias_source_control_mode), .parallel_mode(parallel_mode));
